//--- hw/cbsio_pkg.sv
// constants shared by the control board supervisor and I/O block
package cbsio_pkg;
	// register byte offsets
	localparam logic [7:0] OUT_LATCH_OFS = 8'h00;
	localparam logic [7:0] AUX_CTRL_OFS = 8'h04;
	localparam logic [7:0] BUF_SEL_OFS = 8'h08;
	localparam logic [7:0] DISP_OFS = 8'h0C;
	localparam logic [7:0] ANA_SEL_OFS = 8'h10;
	localparam logic [7:0] POT_OFS = 8'h14;
	localparam logic [7:0] SER_OFS = 8'h18;
	localparam logic [7:0] TEST_LED_OFS = 8'h1C;
	localparam logic [7:0] INPUTS_OFS = 8'h20;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h24;
	localparam logic [7:0] IRQ_EN_OFS = 8'h28;
	localparam logic [7:0] IRQ_CLR_OFS = 8'h2C;
	// field positions
	localparam int AUX_OUT_POS = 4;
	localparam int BUF_EN_POS = 3;
	localparam int DISP_WR_POS = 8;
	localparam int POT_IDX_POS = 8;
	localparam int IN_AUX_POS = 4;
	localparam int IN_DISP_POS = 8;
	localparam int IN_FULL_POS = 16;
	localparam int IN_SUPLOW_POS = 17;
	localparam int IN_TEST_POS = 18;
	localparam int IN_BUSY_POS = 19;
	// interrupt status bits
	localparam int IRQ_WDOG = 0;
	localparam int IRQ_SUPLOW = 1;
	localparam int IRQ_TEST = 2;
	localparam int IRQ_POT = 3;
	localparam int IRQ_BITS = 4;
	// reset values
	localparam logic [31:0] OUT_LATCH_RST = 32'h0000_0000;
	localparam logic [31:0] AUX_CTRL_RST = 32'h0000_0000;
	localparam logic [1:0] SER_RX_RST = 2'h0;
	// timing
	localparam longint CLK_HZ = 125_000_000;
	localparam longint WDOG_TIMEOUT_MS = 1000;
	localparam longint WDOG_CYCLES = WDOG_TIMEOUT_MS * CLK_HZ / 1000;
	localparam longint RST_PULSE_NS = 1000;
	localparam int RST_PULSE_CYCLES = int'((RST_PULSE_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
	localparam int POT_HALF_NS = 80;
	localparam int POT_HALF_CYCLES = int'((POT_HALF_NS * CLK_HZ + 999_999_999) / 1_000_000_000);
	localparam int POT_BITS = 9;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {CBSIO_POT_IDLE, CBSIO_POT_LOW, CBSIO_POT_HIGH} cbsio_pot_st_t;
endpackage

//--- hw/cbsio_top.sv
// supervisor, serial routing and board I/O of the transmitter control board
// Function
// - reset pulse when strobe idle one second
// - hold reset while supply below threshold
// - reset asserted closes programming path switch
// - indicator lit while programming connector used
// - select lines low/high start self test
// - self-test outcome shown on indicator bank
// - first port is sole RS-485 master
// - second port receives from one channel
// - second port transmits on all three channels
// - switch closed selects full transmitter routing
// - remote input high or open reads low
// - aux output driver off when used as input
// - decode enables one buffer at a time
// - output latches hold system and remote levels
// - display buffer reads and writes by direction
// - analog switches select sample to controller
// - drive serial data, clock, enables to pots
// - pots scale signals eighty to 120 percent
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
module cbsio_top #(
	parameter longint WDOG_CYCLES = cbsio_pkg::WDOG_CYCLES,
	parameter int SYS_OUT_W = 8,
	parameter int PMON_W = 4,
	parameter int ANA_CH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	// supervisor and programming
	input wire logic watchdog_strobe,
	input wire logic supply_low,
	input wire logic prog_reset_n,
	input wire logic prog_connector_active,
	output logic controller_reset_n,
	output logic prog_path_close,
	output logic programming_indicator,
	// self test
	input wire logic self_test_sel1,
	input wire logic self_test_sel2,
	output logic [7:0] test_result_led,
	// serial ports
	input wire logic bus1_tx,
	input wire logic bus1_tx_en,
	output logic bus485_tx,
	output logic bus485_de,
	input wire logic bus485_rx,
	output logic bus1_rx,
	input wire logic port2_tx,
	output logic port2_rx,
	input wire logic [2:0] chan_rx,
	output logic [2:0] chan_tx,
	// operation select and power monitoring
	input wire logic operation_select_switch,
	input wire logic [PMON_W-1:0] pa_pmon,
	input wire logic [PMON_W-1:0] exc_pmon,
	output logic [PMON_W-1:0] sys_pmon,
	output logic full_tx_mode,
	// digital I/O
	input wire logic [3:0] remote_above_thr,
	input wire logic [3:0] aux_above_thr,
	output logic [3:0] aux_drv_on,
	output logic [3:0] remote_out_oe,
	output logic [SYS_OUT_W-1:0] sys_ctrl,
	output logic [7:0] buf_enable,
	// display buffer
	input wire logic [7:0] disp_data_i,
	output logic [7:0] disp_data_o,
	output logic disp_data_oe,
	// analog sample switches
	output logic [ANA_CH/2-1:0] analog_sample_switch_a,
	output logic [ANA_CH/2-1:0] analog_sample_switch_b,
	// trim potentiometers
	output logic pot_sdata,
	output logic pot_sclk,
	output logic [1:0] pot_cs_n
);
	localparam int AW = $clog2(ANA_CH);

	logic aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q, wmask_q;
	logic wr_go;
	logic [31:0] out_latch_q, aux_ctrl_q;
	logic [3:0] buf_sel_q;
	logic [8:0] disp_q;
	logic [AW-1:0] ana_sel_q;
	logic [1:0] ser_rx_q;
	logic [7:0] test_led_q;
	logic [cbsio_pkg::IRQ_BITS-1:0] irq_stat_q, irq_en_q, irq_set, irq_clr;
	logic [31:0] wdog_cnt_q;
	logic strobe_q, wdog_fire;
	logic [7:0] rst_cnt_q;
	logic test_req, test_req_q;
	logic sup_q;
	cbsio_pkg::cbsio_pot_st_t pot_st_q;
	logic [cbsio_pkg::POT_BITS-1:0] pot_sh_q;
	logic [3:0] pot_bit_q;
	logic [7:0] pot_div_q;
	logic pot_dev_q, pot_start, pot_done;
	logic [31:0] inputs_w;

	// write path: aw and w in either order
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign wr_go = aw_have_q && w_have_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wmask_q <= 32'h0000_0000;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wmask_q <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
					{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end else if (wr_go) begin
				w_have_q <= 1'b0;
			end
		end
	end

	// write response; unmapped word addresses answer with slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cbsio_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awaddr_q[1:0] != 2'h0 || awaddr_q > cbsio_pkg::IRQ_CLR_OFS
				|| awaddr_q == cbsio_pkg::INPUTS_OFS || awaddr_q == cbsio_pkg::IRQ_STAT_OFS)
				? cbsio_pkg::RESP_SLVERR : cbsio_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [31:0] m);
		merge = (old & ~m) | (d & m);
	endfunction

	// output latches for system controls and remote outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_latch_q <= cbsio_pkg::OUT_LATCH_RST;
		end else if (wr_go && awaddr_q == cbsio_pkg::OUT_LATCH_OFS) begin
			out_latch_q <= merge(out_latch_q, wdata_q, wmask_q);
		end
	end

	// aux direction and output levels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aux_ctrl_q <= cbsio_pkg::AUX_CTRL_RST;
		end else if (wr_go && awaddr_q == cbsio_pkg::AUX_CTRL_OFS) begin
			aux_ctrl_q <= merge(aux_ctrl_q, wdata_q, wmask_q);
		end
	end

	// small control registers written whole
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			buf_sel_q <= 4'h0;
			disp_q <= 9'h000;
			ana_sel_q <= '0;
			ser_rx_q <= cbsio_pkg::SER_RX_RST;
			test_led_q <= 8'h00;
			irq_en_q <= '0;
		end else if (wr_go && wmask_q[0]) begin
			if (awaddr_q == cbsio_pkg::BUF_SEL_OFS) begin
				buf_sel_q <= wdata_q[3:0];
			end else if (awaddr_q == cbsio_pkg::DISP_OFS) begin
				disp_q <= wdata_q[8:0];
			end else if (awaddr_q == cbsio_pkg::ANA_SEL_OFS) begin
				ana_sel_q <= wdata_q[AW-1:0];
			end else if (awaddr_q == cbsio_pkg::SER_OFS) begin
				ser_rx_q <= wdata_q[1:0];
			end else if (awaddr_q == cbsio_pkg::TEST_LED_OFS) begin
				test_led_q <= wdata_q[7:0];
			end else if (awaddr_q == cbsio_pkg::IRQ_EN_OFS) begin
				irq_en_q <= wdata_q[cbsio_pkg::IRQ_BITS-1:0];
			end
		end
	end

	// live input view for software
	always_comb begin
		inputs_w = 32'h0000_0000;
		inputs_w[3:0] = ~remote_above_thr;
		inputs_w[cbsio_pkg::IN_AUX_POS +: 4] = ~aux_above_thr;
		inputs_w[cbsio_pkg::IN_DISP_POS +: 8] = disp_data_i;
		inputs_w[cbsio_pkg::IN_FULL_POS] = operation_select_switch;
		inputs_w[cbsio_pkg::IN_SUPLOW_POS] = supply_low;
		inputs_w[cbsio_pkg::IN_TEST_POS] = test_req;
		inputs_w[cbsio_pkg::IN_BUSY_POS] = pot_st_q != cbsio_pkg::CBSIO_POT_IDLE;
	end

	// read path: data held until rready
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= cbsio_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= cbsio_pkg::RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			if (s_axi_araddr == cbsio_pkg::OUT_LATCH_OFS) begin
				s_axi_rdata <= out_latch_q;
			end else if (s_axi_araddr == cbsio_pkg::AUX_CTRL_OFS) begin
				s_axi_rdata <= aux_ctrl_q;
			end else if (s_axi_araddr == cbsio_pkg::BUF_SEL_OFS) begin
				s_axi_rdata <= {28'h0, buf_sel_q};
			end else if (s_axi_araddr == cbsio_pkg::DISP_OFS) begin
				s_axi_rdata <= {23'h0, disp_q};
			end else if (s_axi_araddr == cbsio_pkg::ANA_SEL_OFS) begin
				s_axi_rdata <= 32'(ana_sel_q);
			end else if (s_axi_araddr == cbsio_pkg::POT_OFS) begin
				s_axi_rdata <= 32'(pot_st_q != cbsio_pkg::CBSIO_POT_IDLE);
			end else if (s_axi_araddr == cbsio_pkg::SER_OFS) begin
				s_axi_rdata <= {30'h0, ser_rx_q};
			end else if (s_axi_araddr == cbsio_pkg::TEST_LED_OFS) begin
				s_axi_rdata <= {24'h0, test_led_q};
			end else if (s_axi_araddr == cbsio_pkg::INPUTS_OFS) begin
				s_axi_rdata <= inputs_w;
			end else if (s_axi_araddr == cbsio_pkg::IRQ_STAT_OFS) begin
				s_axi_rdata <= 32'(irq_stat_q);
			end else if (s_axi_araddr == cbsio_pkg::IRQ_EN_OFS) begin
				s_axi_rdata <= 32'(irq_en_q);
			end else begin
				s_axi_rresp <= cbsio_pkg::RESP_SLVERR; // clear register is write-only
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// watchdog: any strobe edge restarts the one-second window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_q <= 1'b0;
			wdog_cnt_q <= 32'h0000_0000;
		end else begin
			strobe_q <= watchdog_strobe;
			if (strobe_q != watchdog_strobe || rst_cnt_q != 8'h00 || supply_low) begin
				wdog_cnt_q <= 32'h0000_0000; // held at zero while in reset
			end else if (wdog_fire) begin
				wdog_cnt_q <= 32'h0000_0000;
			end else begin
				wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
			end
		end
	end
	assign wdog_fire = wdog_cnt_q == 32'(WDOG_CYCLES - 1) && strobe_q == watchdog_strobe
		&& rst_cnt_q == 8'h00 && !supply_low;

	// brief reset pulse after a missed strobe
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt_q <= 8'h00;
		end else if (wdog_fire) begin
			rst_cnt_q <= 8'(cbsio_pkg::RST_PULSE_CYCLES);
		end else if (rst_cnt_q != 8'h00) begin
			rst_cnt_q <= rst_cnt_q - 8'h01;
		end
	end

	// reset output and programming path, registered so they never glitch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			controller_reset_n <= 1'b0;
			prog_path_close <= 1'b1;
			programming_indicator <= 1'b0;
		end else begin
			controller_reset_n <= !(supply_low || wdog_fire || rst_cnt_q > 8'h01);
			prog_path_close <= supply_low || wdog_fire || rst_cnt_q > 8'h01
				|| !prog_reset_n;
			programming_indicator <= prog_connector_active;
		end
	end

	// self test request
	assign test_req = !self_test_sel1 && self_test_sel2;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_req_q <= 1'b0;
			sup_q <= 1'b0;
			test_result_led <= 8'h00;
		end else begin
			test_req_q <= test_req;
			sup_q <= supply_low;
			test_result_led <= test_led_q;
		end
	end

	// interrupt events, set wins over a clear in the same cycle
	always_comb begin
		irq_set = '0;
		irq_set[cbsio_pkg::IRQ_WDOG] = wdog_fire;
		irq_set[cbsio_pkg::IRQ_SUPLOW] = supply_low && !sup_q;
		irq_set[cbsio_pkg::IRQ_TEST] = test_req && !test_req_q;
		irq_set[cbsio_pkg::IRQ_POT] = pot_done;
		irq_clr = '0;
		if (wr_go && wmask_q[0] && awaddr_q == cbsio_pkg::IRQ_CLR_OFS) begin
			irq_clr = wdata_q[cbsio_pkg::IRQ_BITS-1:0];
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			irq <= |(irq_stat_q & irq_en_q);
		end
	end

	// serial ports
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus485_tx <= 1'b1;
			bus485_de <= 1'b0;
			bus1_rx <= 1'b1;
			port2_rx <= 1'b1;
			chan_tx <= 3'h7;
		end else begin
			bus485_tx <= bus1_tx;
			bus485_de <= bus1_tx_en; // driver enabled only while bus1_tx_en is high; the far node can drive the bus only while it is low
			bus1_rx <= bus485_rx;
			port2_rx <= (ser_rx_q < 2'h3) ? chan_rx[ser_rx_q] : 1'b1;
			chan_tx <= {3{port2_tx}};
		end
	end

	// operation select and power monitor routing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			full_tx_mode <= 1'b0;
			sys_pmon <= '0;
		end else begin
			full_tx_mode <= operation_select_switch;
			sys_pmon <= operation_select_switch ? pa_pmon : exc_pmon;
		end
	end

	// digital outputs and buffer decode
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sys_ctrl <= '0;
			remote_out_oe <= 4'h0;
			aux_drv_on <= 4'h0;
			buf_enable <= 8'h00;
			disp_data_o <= 8'h00;
			disp_data_oe <= 1'b0;
		end else begin
			sys_ctrl <= out_latch_q[SYS_OUT_W-1:0];
			remote_out_oe <= out_latch_q[11:8]; // open drain pulls low while set
			// a line set as input never has its driver on
			aux_drv_on <= aux_ctrl_q[3:0] & aux_ctrl_q[cbsio_pkg::AUX_OUT_POS +: 4];
			buf_enable <= buf_sel_q[cbsio_pkg::BUF_EN_POS]
				? 8'(8'h01 << buf_sel_q[2:0]) : 8'h00;
			disp_data_o <= disp_q[7:0];
			disp_data_oe <= disp_q[cbsio_pkg::DISP_WR_POS];
		end
	end

	// analog sample select, one switch closed at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_sample_switch_a <= '0;
			analog_sample_switch_b <= '0;
		end else begin
			analog_sample_switch_a <= ana_sel_q[AW-1] ? '0
				: (ANA_CH/2)'(1) << ana_sel_q[AW-2:0];
			analog_sample_switch_b <= ana_sel_q[AW-1]
				? (ANA_CH/2)'(1) << ana_sel_q[AW-2:0] : '0;
		end
	end

	// trim pot writes: wiper select bit then 8-bit code, msb first
	// code 0 gives 80 percent, full scale 120 percent of the input
	assign pot_start = wr_go && wmask_q[0] && awaddr_q == cbsio_pkg::POT_OFS
		&& pot_st_q == cbsio_pkg::CBSIO_POT_IDLE;
	assign pot_done = pot_st_q == cbsio_pkg::CBSIO_POT_HIGH && pot_div_q == 8'h00
		&& pot_bit_q == 4'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pot_st_q <= cbsio_pkg::CBSIO_POT_IDLE;
			pot_sh_q <= '0;
			pot_bit_q <= 4'h0;
			pot_div_q <= 8'h00;
			pot_dev_q <= 1'b0;
		end else begin
			case (pot_st_q)
				cbsio_pkg::CBSIO_POT_IDLE: begin
					if (pot_start) begin
						pot_sh_q <= {wdata_q[cbsio_pkg::POT_IDX_POS], wdata_q[7:0]};
						pot_dev_q <= wdata_q[cbsio_pkg::POT_IDX_POS + 1];
						pot_bit_q <= 4'(cbsio_pkg::POT_BITS - 1);
						pot_div_q <= 8'(cbsio_pkg::POT_HALF_CYCLES - 1);
						pot_st_q <= cbsio_pkg::CBSIO_POT_LOW;
					end
				end
				cbsio_pkg::CBSIO_POT_LOW: begin
					if (pot_div_q != 8'h00) begin
						pot_div_q <= pot_div_q - 8'h01;
					end else begin
						pot_div_q <= 8'(cbsio_pkg::POT_HALF_CYCLES - 1);
						pot_st_q <= cbsio_pkg::CBSIO_POT_HIGH;
					end
				end
				default: begin
					if (pot_div_q != 8'h00) begin
						pot_div_q <= pot_div_q - 8'h01;
					end else if (pot_bit_q == 4'h0) begin
						pot_st_q <= cbsio_pkg::CBSIO_POT_IDLE;
					end else begin
						pot_div_q <= 8'(cbsio_pkg::POT_HALF_CYCLES - 1);
						pot_bit_q <= pot_bit_q - 4'h1;
						pot_sh_q <= {pot_sh_q[cbsio_pkg::POT_BITS-2:0], 1'b0};
						pot_st_q <= cbsio_pkg::CBSIO_POT_LOW;
					end
				end
			endcase
		end
	end

	// pot pins registered from the shifter state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pot_sdata <= 1'b0;
			pot_sclk <= 1'b0;
			pot_cs_n <= 2'h3;
		end else begin
			pot_sdata <= pot_sh_q[cbsio_pkg::POT_BITS-1];
			pot_sclk <= pot_st_q == cbsio_pkg::CBSIO_POT_HIGH;
			pot_cs_n <= (pot_st_q == cbsio_pkg::CBSIO_POT_IDLE) ? 2'h3
				: (pot_dev_q ? 2'h1 : 2'h2);
		end
	end
endmodule // cbsio_top

//--- bench/cbsio_checker.sv
// port-level assertions for the control board supervisor and I/O block
module cbsio_checker #(
	parameter int PMON_W = 4,
	parameter int ANA_CH = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic port2_tx,
	input wire logic [2:0] chan_tx,
	input wire logic bus1_tx,
	input wire logic bus1_tx_en,
	input wire logic bus485_tx,
	input wire logic bus485_de,
	input wire logic bus485_rx,
	input wire logic bus1_rx,
	input wire logic operation_select_switch,
	input wire logic [PMON_W-1:0] pa_pmon,
	input wire logic [PMON_W-1:0] exc_pmon,
	input wire logic [PMON_W-1:0] sys_pmon,
	input wire logic full_tx_mode,
	input wire logic supply_low,
	input wire logic controller_reset_n,
	input wire logic prog_path_close,
	input wire logic prog_connector_active,
	input wire logic programming_indicator,
	input wire logic [7:0] buf_enable,
	input wire logic [ANA_CH/2-1:0] analog_sample_switch_a,
	input wire logic [ANA_CH/2-1:0] analog_sample_switch_b,
	input wire logic pot_sdata,
	input wire logic pot_sclk,
	input wire logic [1:0] pot_cs_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// registered paths judged once out of reset
	fan_out_a: assert property ($past(aresetn) |-> chan_tx == {3{$past(port2_tx)}})
		else $error("fan-out wrong");
	bus_drive_a: assert property ($past(aresetn) |->
		bus485_de == $past(bus1_tx_en) && bus485_tx == $past(bus1_tx))
		else $error("bus drive wrong");
	bus_listen_a: assert property ($past(aresetn) |-> bus1_rx == $past(bus485_rx))
		else $error("bus receive wrong");
	full_route_a: assert property ($past(aresetn) && $past(operation_select_switch) |->
		full_tx_mode && sys_pmon == $past(pa_pmon))
		else $error("full routing wrong");
	exc_route_a: assert property ($past(aresetn) && !$past(operation_select_switch) |->
		!full_tx_mode && sys_pmon == $past(exc_pmon))
		else $error("exciter routing wrong");
	supply_hold_a: assert property (supply_low |=> !controller_reset_n)
		else $error("reset released");
	path_close_a: assert property (!controller_reset_n |-> ##[0:1] prog_path_close)
		else $error("path open in reset");
	prog_lamp_a: assert property ($past(aresetn) |->
		programming_indicator == $past(prog_connector_active))
		else $error("indicator wrong");
	one_buffer_a: assert property ($onehot0(buf_enable))
		else $error("two buffers on");
	one_sample_a: assert property ($onehot0({analog_sample_switch_b, analog_sample_switch_a}))
		else $error("two samples on");
	pot_select_a: assert property (pot_cs_n != 2'h0)
		else $error("both pots on");
	pot_setup_a: assert property ($rose(pot_sclk) |-> $stable(pot_sdata))
		else $error("pot data moved");
	cover property ($fell(controller_reset_n) && !supply_low);
	cover property ($rose(full_tx_mode));
	cover property (!pot_cs_n[1] && $rose(pot_sclk));
endmodule // cbsio_checker

bind cbsio_top cbsio_checker #(.PMON_W(PMON_W), .ANA_CH(ANA_CH)) i_cbsio_checker (.aclk, .aresetn,
	.port2_tx, .chan_tx, .bus1_tx, .bus1_tx_en, .bus485_tx, .bus485_de, .bus485_rx, .bus1_rx,
	.operation_select_switch, .pa_pmon, .exc_pmon, .sys_pmon, .full_tx_mode, .supply_low,
	.controller_reset_n, .prog_path_close, .prog_connector_active, .programming_indicator,
	.buf_enable, .analog_sample_switch_a, .analog_sample_switch_b, .pot_sdata, .pot_sclk,
	.pot_cs_n);

//--- bench/cbsio_rs485_node.sv
// rs-485 node model on the far side of the first serial port
module cbsio_rs485_node (
	input wire logic bus485_tx,
	input wire logic bus485_de,
	input wire logic talk,
	input wire logic reply,
	output logic bus485_rx
);
	timeunit 1ns;
	timeprecision 1ps;
	// board drive wins; a released bus rests at mark
	always_comb begin
		if (bus485_de) begin
			bus485_rx = bus485_tx;
		end else if (talk) begin
			bus485_rx = reply;
		end else begin
			bus485_rx = 1'b1;
		end
	end
endmodule // cbsio_rs485_node

//--- bench/tb.sv
// self-checking bench for the control board supervisor and I/O block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam longint WD = 200;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, irq;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, pot_cs_n;
	logic watchdog_strobe = 0, supply_low = 0, prog_reset_n = 1, prog_connector_active = 0;
	logic self_test_sel1 = 1, self_test_sel2 = 0, bus1_tx = 1, bus1_tx_en = 0, port2_tx = 1;
	logic operation_select_switch = 0, talk = 0, reply = 1, strobe_on = 1;
	logic controller_reset_n, prog_path_close, programming_indicator, bus485_tx, bus485_de;
	logic bus485_rx, bus1_rx, port2_rx, full_tx_mode, disp_data_oe, pot_sdata, pot_sclk;
	logic [2:0] chan_rx = 3'h7, chan_tx;
	logic [3:0] pa_pmon = 4'hA, exc_pmon = 4'h5, remote_above_thr = 4'h5, aux_above_thr = 4'hC;
	logic [3:0] sys_pmon, aux_drv_on, remote_out_oe;
	logic [7:0] disp_data_i = 8'h3C, test_result_led, sys_ctrl, buf_enable, disp_data_o;
	logic [7:0] analog_sample_switch_a, analog_sample_switch_b;
	int checks = 0, bad_count = 0;

	cbsio_top #(.WDOG_CYCLES(WD)) i_cbsio_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .watchdog_strobe,
		.supply_low, .prog_reset_n, .prog_connector_active, .controller_reset_n,
		.prog_path_close, .programming_indicator, .self_test_sel1, .self_test_sel2,
		.test_result_led, .bus1_tx, .bus1_tx_en, .bus485_tx, .bus485_de, .bus485_rx, .bus1_rx,
		.port2_tx, .port2_rx, .chan_rx, .chan_tx, .operation_select_switch, .pa_pmon,
		.exc_pmon, .sys_pmon, .full_tx_mode, .remote_above_thr, .aux_above_thr, .aux_drv_on,
		.remote_out_oe, .sys_ctrl, .buf_enable, .disp_data_i, .disp_data_o, .disp_data_oe,
		.analog_sample_switch_a, .analog_sample_switch_b, .pot_sdata, .pot_sclk, .pot_cs_n);
	cbsio_rs485_node i_cbsio_rs485_node (.bus485_tx, .bus485_de, .talk, .reply, .bus485_rx);

	// 125 MHz clock
	always #4 aclk = ~aclk;
	// keep-alive strobe
	always begin
		repeat (50) @(posedge aclk);
		if (strobe_on) watchdog_strobe <= ~watchdog_strobe;
	end
	// hang guard
	initial begin
		#200000;
		bad_count++;
		conclude();
	end

	task automatic conclude;
		if (bad_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// bus tasks; ready is sampled before the edge updates land
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
			input logic [1:0] r = 2'h0);
		bit ta, tw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		ta = 0;
		tw = 0;
		while (!(ta && tw)) begin
			@(posedge aclk);
			if (s_axi_awready && !ta) begin
				s_axi_awvalid <= 0;
				ta = 1;
			end
			if (s_axi_wready && !tw) begin
				s_axi_wvalid <= 0;
				tw = 1;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 0;
		chk(32'(s_axi_bresp), 32'(r));
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
			input logic [1:0] r = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 0;
		chk(s_axi_rdata & m, e);
		chk(32'(s_axi_rresp), 32'(r));
	endtask

	// collect pot bits at sclk rise
	task automatic cap(output logic [8:0] sh, output int nb);
		logic p;
		sh = 9'h0;
		nb = 0;
		p = 0;
		repeat (400) begin
			@(posedge aclk);
			if (pot_sclk && !p && pot_cs_n === 2'h1) begin
				sh = {sh[7:0], pot_sdata};
				nb++;
			end
			p = pot_sclk;
		end
	endtask

	initial begin
		logic [8:0] sh;
		int nb, n;
		tick(20);
		aresetn <= 1;
		rd(cbsio_pkg::OUT_LATCH_OFS, 32'hFFF, 32'h0);
		wr(cbsio_pkg::OUT_LATCH_OFS, 32'h0A5C);
		wr(cbsio_pkg::OUT_LATCH_OFS, 32'hFFFF_FFFF, 4'h2);
		wr(cbsio_pkg::AUX_CTRL_OFS, 32'hF3);
		wr(cbsio_pkg::DISP_OFS, 32'h1A5);
		wr(cbsio_pkg::TEST_LED_OFS, 32'h5A);
		tick(2);
		chk(32'({sys_ctrl, remote_out_oe, aux_drv_on}), 32'h5CF3);
		chk(32'({disp_data_o, disp_data_oe, test_result_led}), 32'h14B5A);
		wr(cbsio_pkg::DISP_OFS, 32'h0);
		rd(cbsio_pkg::INPUTS_OFS, 32'hFFFF, 32'h3C3A);
		for (int i = 0; i < 16; i++) begin
			wr(cbsio_pkg::ANA_SEL_OFS, 32'(i));
			wr(cbsio_pkg::BUF_SEL_OFS, 32'(8 + i % 8));
			tick(2);
			chk(32'({analog_sample_switch_b, analog_sample_switch_a}), 32'h1 << i);
			chk(32'(buf_enable), 32'h1 << (i % 8));
		end
		for (int c = 0; c < 4; c++) begin
			wr(cbsio_pkg::SER_OFS, 32'(c));
			chan_rx <= (c == 3) ? 3'h0 : ~3'(1 << c);
			port2_tx <= c[0];
			tick(3);
			chk(32'(port2_rx), 32'(c == 3));
			chk(32'(chan_tx), c[0] ? 32'h7 : 32'h0);
		end
		operation_select_switch <= 1;
		bus1_tx_en <= 1;
		bus1_tx <= 0;
		tick(3);
		chk(32'({full_tx_mode, sys_pmon, bus485_de, bus1_rx}), 32'h6A);
		operation_select_switch <= 0;
		bus1_tx_en <= 0;
		{talk, reply} <= 2'h2;
		tick(3);
		chk(32'({full_tx_mode, sys_pmon, bus485_de, bus1_rx}), 32'h14);
		talk <= 0;
		tick(3);
		chk(32'(bus1_rx), 32'h1);
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'hF, 32'h0);
		{self_test_sel1, self_test_sel2} <= 2'h1;
		tick(3);
		rd(cbsio_pkg::INPUTS_OFS, 32'h4_0000, 32'h4_0000);
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'hF, 32'h4);
		chk(32'(irq), 32'h0);
		wr(cbsio_pkg::IRQ_EN_OFS, 32'h4);
		tick(2);
		chk(32'(irq), 32'h1);
		wr(cbsio_pkg::IRQ_CLR_OFS, 32'h4);
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'hF, 32'h0);
		chk(32'(irq), 32'h0);
		wr(cbsio_pkg::IRQ_EN_OFS, 32'hF);
		supply_low <= 1;
		tick(300);
		chk(32'({controller_reset_n, irq}), 32'h1);
		supply_low <= 0;
		prog_reset_n <= 0;
		prog_connector_active <= 1;
		tick(3);
		chk(32'({prog_path_close, programming_indicator}), 32'h3);
		prog_reset_n <= 1;
		prog_connector_active <= 0;
		tick(3);
		chk(32'({prog_path_close, programming_indicator, controller_reset_n}), 32'h1);
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'h3, 32'h2);
		wr(cbsio_pkg::IRQ_CLR_OFS, 32'hF);
		@(watchdog_strobe);
		strobe_on <= 0;
		n = 0;
		while (controller_reset_n && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(n >= WD && n <= WD + 4), 32'h1);
		n = 0;
		while (!controller_reset_n && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk(32'(n), 32'(cbsio_pkg::RST_PULSE_CYCLES));
		strobe_on <= 1;
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'h1, 32'h1);
		wr(cbsio_pkg::IRQ_CLR_OFS, 32'hF);
		fork
			cap(sh, nb);
			begin
				wr(cbsio_pkg::POT_OFS, 32'h3A5);
				rd(cbsio_pkg::POT_OFS, 32'h1, 32'h1);
				wr(cbsio_pkg::POT_OFS, 32'h0FF);
			end
		join
		chk(32'({nb[3:0], sh}), 32'h13A5);
		rd(cbsio_pkg::IRQ_STAT_OFS, 32'h8, 32'h8);
		rd(8'h30, 32'hFFFF_FFFF, 32'h0, cbsio_pkg::RESP_SLVERR);
		wr(cbsio_pkg::INPUTS_OFS, 32'h0, 4'hF, cbsio_pkg::RESP_SLVERR);
		wr(8'h06, 32'h0, 4'hF, cbsio_pkg::RESP_SLVERR);
		conclude();
	end
endmodule // tb
